// ---- mad_pkg.sv ----
package mad_pkg;

    // ****************************************************
    // register indices (byte address is four times these)
    // ****************************************************
    localparam logic [7:0] IDX_STATUS   = 8'h12;
    localparam logic [7:0] IDX_IRQ_EN   = 8'h16;
    localparam logic [7:0] IDX_POLARITY = 8'h17;
    localparam logic [7:0] IDX_BIAS     = 8'h3a;
    localparam logic [7:0] IDX_PIN_SEL  = 8'h40;
    localparam logic [7:0] IDX_CLK_CTRL = 8'h41;
    localparam logic [7:0] IDX_ROUTE    = 8'h42;
    localparam logic [7:0] IDX_PULL     = 8'h43;

    // ****************************************************
    // field positions
    // ****************************************************
    localparam int BIT_SHORT      = 10;
    localparam int BIT_DETECT     = 9;
    localparam int PIN_STAT_LSB   = 0;
    localparam int SHORT_THR_LSB  = 6;
    localparam int DET_THR_LSB    = 3;
    localparam int BIAS_EN_BIT    = 2;
    localparam int CLK_EN_BIT     = 0;
    localparam int CLK_DIV_LSB    = 1;
    localparam int ROUTE_PIN1_BIT = 0;
    localparam int ROUTE_MCLK_BIT = 1;
    localparam int ROUTE_AIF_BIT  = 2;
    localparam int ROUTE_PIN6_BIT = 3;
    localparam int ROUTE_TRIS_BIT = 4;
    localparam int PULLDN_LSB     = 8;

    // ****************************************************
    // widths and reset values
    // ****************************************************
    localparam int NUM_PINS  = 6;
    localparam int DIV_W     = 4;
    localparam int SEL_W     = 4;
    localparam logic [1:0] RST_FLAGS     = 2'h0;
    localparam logic [1:0] RST_IRQ_EN    = 2'h0;
    localparam logic [1:0] RST_POLARITY  = 2'h0;
    localparam logic [1:0] RST_SHORT_THR = 2'h0;
    localparam logic [2:0] RST_DET_THR   = 3'h0;
    localparam logic       RST_BIAS_EN   = 1'b0;
    localparam logic [4:0] RST_ROUTE     = 5'h00;
    localparam logic [3:0] RST_CLK_DIV   = 4'h0;

    // ****************************************************
    // pin function codes
    // ****************************************************
    localparam logic [3:0] FN_INPUT   = 4'h0;
    localparam logic [3:0] FN_CLK     = 4'h1;
    localparam logic [3:0] FN_LOW     = 4'h2;
    localparam logic [3:0] FN_HIGH    = 4'h3;
    localparam logic [3:0] FN_LOCK    = 4'h4;
    localparam logic [3:0] FN_TEMP    = 4'h5;
    localparam logic [3:0] FN_IRQ     = 4'h7;
    localparam logic [3:0] FN_DET_A   = 4'h8;
    localparam logic [3:0] FN_SHORT_A = 4'h9;
    localparam logic [3:0] FN_DET_B   = 4'ha;
    localparam logic [3:0] FN_SHORT_B = 4'hb;

    // ****************************************************
    // carriers
    // ****************************************************
    typedef struct packed {
        logic       short_det;
        logic       detect;
    } mad_det_t;

    typedef struct packed {
        logic [1:0] short_thr;
        logic [2:0] det_thr;
        logic       enable;
    } mad_bias_cfg_t;

endpackage : mad_pkg

// ---- mad_sync.sv ----
`timescale 1ns/1ns
module mad_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // first stage feeds only the second
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule : mad_sync

// ---- mad_clk_div.sv ----
`timescale 1ns/1ns
module mad_clk_div #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // control
    input  wire logic             enable,
    input  wire logic [DIV_W-1:0] div,
    // divided clock, period 2*(div+1) cycles
    output logic                  clk_out
);

    logic [DIV_W-1:0] count_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= '0;
            clk_out   <= 1'b0;
        end else if (!enable) begin
            // held low while disabled so the pin sees no runt pulse
            count_reg <= '0;
            clk_out   <= 1'b0;
        end else if (count_reg >= div) begin
            count_reg <= '0;
            clk_out   <= ~clk_out;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

endmodule : mad_clk_div

// ---- mad_top.sv ----
// Functional notes
// - both detections feed codec interrupt logic, each with own enable and polarity.
// - detection flags are sticky and readable until software clears them.
// - writing one clears a flag; zero leaves it untouched.
// - short flag sits at bit 10 of status register 12h, reset 0.
// - current-detect flag sits at bit 9 of status register 12h, reset 0.
// - irq enables at bits 10 and 9 of 16h, reset 0.
// - a flag reaches codec irq only while its enable is 1.
// - polarity selects at bits 10 and 9 of 17h, reset 0.
// - flags are set by detector level seen through its polarity select.
// - short threshold code in 3Ah bits 7:6, reset 00, sent to detector.
// - current threshold code in 3Ah bits 5:3, reset 000.
// - bias detect enable at 3Ah bit 2 turns both detectors on.
// - function 1000 drives current detect, 1001 short detect onto pin.
// - detection status on a pin is high when asserted.
// - polarity selects never invert what a pin drives.
// - both detections also go to the main interrupt controller.
// - pin 2 takes alternative master clock when master clock source is 1.
// - function 0001 drives divided system clock onto the pin.
// - divided clock toggles only while enabled, else held inactive.
// - function codes decode input, clock, low, high, lock, temp, irq, detections.
`timescale 1ns/1ns
module mad_top (
    // clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // ahb-lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic [31:0]                    hrdata,
    output logic                           hresp,
    // analogue detector interface
    input  wire mad_pkg::mad_det_t         det_raw,
    output mad_pkg::mad_bias_cfg_t         bias_cfg,
    // other on-chip status levels
    input  wire logic                      fll_lock_raw,
    input  wire logic                      temp_ok_raw,
    // interrupt outputs
    output logic                           codec_irq,
    output mad_pkg::mad_det_t              main_irq_det,
    // gpio pins
    input  wire logic [5:0]                gpio_in,
    output logic      [5:0]                gpio_out,
    output logic      [5:0]                gpio_oe_n,
    output logic      [5:0]                pin_pullup_en,
    output logic      [5:0]                pin_pulldown_en,
    output logic                           alt_master_clock_sel
);

    // ****************************************************
    // synchronisers
    // ****************************************************
    logic [9:0]        sync_q;
    mad_pkg::mad_det_t det_s;
    logic              lock_s;
    logic              temp_s;
    logic [5:0]        pin_s;

    mad_sync #(
        .WIDTH (10)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({gpio_in, temp_ok_raw, fll_lock_raw, det_raw}),
        .q       (sync_q)
    );

    assign det_s  = sync_q[1:0];
    assign lock_s = sync_q[2];
    assign temp_s = sync_q[3];
    assign pin_s  = sync_q[9:4];

    // ****************************************************
    // bus slave, one wait state per transfer
    // ****************************************************
    logic       busy_reg;
    logic       wr_reg;
    logic [7:0] idx_reg;
    logic       addr_ok_reg;
    logic       take;
    logic       wr_done;
    logic [15:0] wdata;

    assign take    = hsel && hready && htrans[1];
    assign wr_done = busy_reg && wr_reg && addr_ok_reg;
    assign wdata   = hwdata[15:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg    <= 1'b0;
            wr_reg      <= 1'b0;
            idx_reg     <= 8'h00;
            addr_ok_reg <= 1'b0;
        end else if (busy_reg) begin
            busy_reg <= 1'b0;
        end else if (take) begin
            busy_reg    <= 1'b1;
            wr_reg      <= hwrite;
            idx_reg     <= haddr[9:2];
            addr_ok_reg <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            // low during the first data-phase cycle, high again after it
            hreadyout <= busy_reg || !take;
            hresp     <= 1'b0;
        end
    end

    // ****************************************************
    // control registers
    // ****************************************************
    logic [1:0]  irq_en_reg;
    logic [1:0]  invert_reg;
    logic [23:0] pin_sel_reg;
    logic        clk_en_reg;
    logic [3:0]  clk_div_reg;
    logic [4:0]  route_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_reg <= mad_pkg::RST_IRQ_EN;
        end else if (wr_done && idx_reg == mad_pkg::IDX_IRQ_EN) begin
            irq_en_reg <= {wdata[mad_pkg::BIT_SHORT], wdata[mad_pkg::BIT_DETECT]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            invert_reg <= mad_pkg::RST_POLARITY;
        end else if (wr_done && idx_reg == mad_pkg::IDX_POLARITY) begin
            invert_reg <= {wdata[mad_pkg::BIT_SHORT], wdata[mad_pkg::BIT_DETECT]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bias_cfg.short_thr <= mad_pkg::RST_SHORT_THR;
            bias_cfg.det_thr   <= mad_pkg::RST_DET_THR;
            bias_cfg.enable    <= mad_pkg::RST_BIAS_EN;
        end else if (wr_done && idx_reg == mad_pkg::IDX_BIAS) begin
            bias_cfg.short_thr <= wdata[mad_pkg::SHORT_THR_LSB +: 2];
            bias_cfg.det_thr   <= wdata[mad_pkg::DET_THR_LSB +: 3];
            bias_cfg.enable    <= wdata[mad_pkg::BIAS_EN_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_sel_reg <= 24'h000000;
        end else if (wr_done && idx_reg == mad_pkg::IDX_PIN_SEL) begin
            pin_sel_reg <= hwdata[23:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_en_reg  <= 1'b0;
            clk_div_reg <= mad_pkg::RST_CLK_DIV;
        end else if (wr_done && idx_reg == mad_pkg::IDX_CLK_CTRL) begin
            clk_en_reg  <= hwdata[mad_pkg::CLK_EN_BIT];
            clk_div_reg <= hwdata[mad_pkg::CLK_DIV_LSB +: mad_pkg::DIV_W];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            route_reg <= mad_pkg::RST_ROUTE;
        end else if (wr_done && idx_reg == mad_pkg::IDX_ROUTE) begin
            route_reg <= hwdata[4:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_pullup_en   <= 6'h00;
            pin_pulldown_en <= 6'h00;
        end else if (wr_done && idx_reg == mad_pkg::IDX_PULL) begin
            pin_pullup_en   <= hwdata[5:0];
            pin_pulldown_en <= hwdata[mad_pkg::PULLDN_LSB +: 6];
        end
    end

    assign alt_master_clock_sel = route_reg[mad_pkg::ROUTE_MCLK_BIT];

    // ****************************************************
    // detection flags
    // ****************************************************
    logic [1:0] flag_reg;
    logic [1:0] det_lvl;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;

    assign det_lvl  = {det_s.short_det, det_s.detect};
    // detectors are off while bias detect is disabled
    assign flag_set = {2{bias_cfg.enable}} & (det_lvl ^ invert_reg);
    assign flag_clr = (wr_done && idx_reg == mad_pkg::IDX_STATUS) ?
                      {wdata[mad_pkg::BIT_SHORT], wdata[mad_pkg::BIT_DETECT]} : 2'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reg <= mad_pkg::RST_FLAGS;
        end else begin
            // set wins over a coincident clear
            flag_reg <= (flag_reg & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            codec_irq    <= 1'b0;
            main_irq_det <= '0;
        end else begin
            codec_irq    <= |(flag_reg & irq_en_reg);
            main_irq_det <= det_s;
        end
    end

    // ****************************************************
    // read data
    // ****************************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        if (addr_ok_reg) begin
            unique case (idx_reg)
                mad_pkg::IDX_STATUS: begin
                    rd_mux[mad_pkg::BIT_SHORT]        = flag_reg[1];
                    rd_mux[mad_pkg::BIT_DETECT]       = flag_reg[0];
                    rd_mux[mad_pkg::PIN_STAT_LSB +: 6] = pin_s;
                end
                mad_pkg::IDX_IRQ_EN: begin
                    rd_mux[mad_pkg::BIT_SHORT]  = irq_en_reg[1];
                    rd_mux[mad_pkg::BIT_DETECT] = irq_en_reg[0];
                end
                mad_pkg::IDX_POLARITY: begin
                    rd_mux[mad_pkg::BIT_SHORT]  = invert_reg[1];
                    rd_mux[mad_pkg::BIT_DETECT] = invert_reg[0];
                end
                mad_pkg::IDX_BIAS: begin
                    rd_mux[mad_pkg::SHORT_THR_LSB +: 2] = bias_cfg.short_thr;
                    rd_mux[mad_pkg::DET_THR_LSB +: 3]   = bias_cfg.det_thr;
                    rd_mux[mad_pkg::BIAS_EN_BIT]        = bias_cfg.enable;
                end
                mad_pkg::IDX_PIN_SEL: begin
                    rd_mux[23:0] = pin_sel_reg;
                end
                mad_pkg::IDX_CLK_CTRL: begin
                    rd_mux[mad_pkg::CLK_EN_BIT]                   = clk_en_reg;
                    rd_mux[mad_pkg::CLK_DIV_LSB +: mad_pkg::DIV_W] = clk_div_reg;
                end
                mad_pkg::IDX_ROUTE: begin
                    rd_mux[4:0] = route_reg;
                end
                mad_pkg::IDX_PULL: begin
                    rd_mux[5:0]                       = pin_pullup_en;
                    rd_mux[mad_pkg::PULLDN_LSB +: 6] = pin_pulldown_en;
                end
                default: begin
                    rd_mux = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (busy_reg && !wr_reg) begin
            hrdata <= rd_mux;
        end
    end

    // ****************************************************
    // clock output divider
    // ****************************************************
    logic div_clk;

    mad_clk_div #(
        .DIV_W (mad_pkg::DIV_W)
    ) u_clk_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (clk_en_reg),
        .div     (clk_div_reg),
        .clk_out (div_clk)
    );

    // ****************************************************
    // pin function multiplexers
    // ****************************************************
    logic [5:0] route_ok;

    // pins whose pads are shared with other functions drive only when freed
    always_comb begin
        route_ok    = {6{~route_reg[mad_pkg::ROUTE_TRIS_BIT]}};
        route_ok[0] = route_ok[0] & route_reg[mad_pkg::ROUTE_PIN1_BIT];
        route_ok[1] = route_ok[1] & ~route_reg[mad_pkg::ROUTE_MCLK_BIT];
        route_ok[2] = route_ok[2] & ~route_reg[mad_pkg::ROUTE_AIF_BIT];
        route_ok[3] = route_ok[3] & ~route_reg[mad_pkg::ROUTE_AIF_BIT];
        route_ok[4] = route_ok[4] & ~route_reg[mad_pkg::ROUTE_AIF_BIT];
        route_ok[5] = route_ok[5] & ~route_reg[mad_pkg::ROUTE_PIN6_BIT];
    end

    genvar p;
    generate
        for (p = 0; p < mad_pkg::NUM_PINS; p = p + 1) begin : g_pin
            logic [3:0] sel;
            logic       lvl;
            logic       drive;

            assign sel = pin_sel_reg[p*mad_pkg::SEL_W +: mad_pkg::SEL_W];

            // detection levels go out raw: polarity selects are not applied
            always_comb begin
                lvl   = 1'b0;
                drive = 1'b1;
                unique case (sel)
                    mad_pkg::FN_CLK:     lvl = div_clk;
                    mad_pkg::FN_LOW:     lvl = 1'b0;
                    mad_pkg::FN_HIGH:    lvl = 1'b1;
                    mad_pkg::FN_LOCK:    lvl = lock_s;
                    mad_pkg::FN_TEMP:    lvl = temp_s;
                    mad_pkg::FN_IRQ:     lvl = codec_irq;
                    mad_pkg::FN_DET_A,
                    mad_pkg::FN_DET_B:   lvl = det_s.detect;
                    mad_pkg::FN_SHORT_A,
                    mad_pkg::FN_SHORT_B: lvl = det_s.short_det;
                    default:             drive = 1'b0;
                endcase
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    gpio_out[p]  <= 1'b0;
                    gpio_oe_n[p] <= 1'b1;
                end else begin
                    gpio_out[p]  <= lvl;
                    gpio_oe_n[p] <= ~(drive && route_ok[p]);
                end
            end
        end
    endgenerate

endmodule : mad_top

// ---- mad_top_sva.sv ----
`timescale 1ns/1ns
module mad_top_sva (
    // clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // ahb-lite side
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    input  wire logic                   hreadyout,
    input  wire logic                   hresp,
    // detector and pin side
    input  wire mad_pkg::mad_det_t      det_raw,
    input  wire mad_pkg::mad_bias_cfg_t bias_cfg,
    input  wire logic                   codec_irq,
    input  wire mad_pkg::mad_det_t      main_irq_det,
    input  wire logic [5:0]             gpio_oe_n,
    input  wire logic                   alt_master_clock_sel
);
    // ****************************************************
    // write decode, assertions
    // ****************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    logic wr_bias;
    logic wr_route;
    logic wr_en;
    assign take     = hsel && hready && htrans[1];
    assign wr_bias  = take && hwrite && haddr == {22'h0, mad_pkg::IDX_BIAS, 2'b00};
    assign wr_route = take && hwrite && haddr == {22'h0, mad_pkg::IDX_ROUTE, 2'b00};
    assign wr_en    = take && hwrite && haddr == {22'h0, mad_pkg::IDX_IRQ_EN, 2'b00};

    a_bus_wait: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("bad wait state");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("not okay");
    a_sync_delay: assert property (main_irq_det == $past(det_raw, 2) || main_irq_det == $past(det_raw, 3))
        else $error("main irq latency");
    a_det_follow: assert property ($stable(det_raw) [*4] |-> main_irq_det == det_raw)
        else $error("main irq stale");
    a_bias_write: assert property (wr_bias |-> ##2 bias_cfg == $past(hwdata[7:2]))
        else $error("bias write lost");
    a_bias_hold: assert property ($changed(bias_cfg) |-> $past(wr_bias, 2))
        else $error("bias changed unwritten");
    a_mclk_write: assert property (wr_route |-> ##2 alt_master_clock_sel == $past(hwdata[1]))
        else $error("mclk write lost");
    a_mclk_pin: assert property (alt_master_clock_sel && $past(alt_master_clock_sel, 2) |-> gpio_oe_n[1])
        else $error("pin 2 driven as clock input");
    a_irq_off: assert property (wr_en ##1 hwdata[10:9] == 2'b00 |-> ##2 !codec_irq)
        else $error("irq with enables clear");

    c_bias_wr: cover property (wr_bias);
    c_irq_rise: cover property ($rose(codec_irq));
    c_alt_clk: cover property ($rose(alt_master_clock_sel));
endmodule : mad_top_sva

// ---- mad_det_model.sv ----
`timescale 1ns/1ns
module mad_det_model (
    // config and load in microamps
    input  wire mad_pkg::mad_bias_cfg_t bias_cfg,
    input  wire logic [15:0]            load_ua,
    // comparator levels
    output mad_pkg::mad_det_t           det_raw
);
    // ****************************************************
    // comparators, dead while detection is off
    // ****************************************************
    always_comb begin
        det_raw.detect    = bias_cfg.enable && load_ua >= 220 + 110 * bias_cfg.det_thr;
        det_raw.short_det = bias_cfg.enable && load_ua >= 450 + 400 * bias_cfg.short_thr;
    end
endmodule : mad_det_model

// ---- mad_top_bench.sv ----
`timescale 1ns/1ns
module mad_top_bench;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        fll_lock_raw, temp_ok_raw, codec_irq, alt_master_clock_sel;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, d, m, r;
    logic [31:0] seed = 32'h4120;
    logic [5:0]  gpio_in, gpio_out, gpio_oe_n, pin_pullup_en, pin_pulldown_en, ext;
    logic [15:0] load_ua;
    localparam logic [7:0] ST = mad_pkg::IDX_STATUS, EN = mad_pkg::IDX_IRQ_EN;
    localparam logic [7:0] PO = mad_pkg::IDX_POLARITY, BI = mad_pkg::IDX_BIAS;
    logic [7:0]  rw_idx [3] = '{EN, PO, BI};
    int          err_total = 0, checks = 0, cyc = 0, t;
    mad_pkg::mad_det_t      det_raw, main_irq_det;
    mad_pkg::mad_bias_cfg_t bias_cfg;

    // released pins show the far side
    assign hready  = hreadyout;
    assign gpio_in = (gpio_out & ~gpio_oe_n) | (ext & gpio_oe_n);

    mad_top mad_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hreadyout, .hrdata, .hresp, .det_raw, .bias_cfg, .fll_lock_raw,
        .temp_ok_raw, .codec_irq, .main_irq_det, .gpio_in, .gpio_out, .gpio_oe_n,
        .pin_pullup_en, .pin_pulldown_en, .alt_master_clock_sel);
    mad_det_model mad_det_model_i (.bias_cfg, .load_ua, .det_raw);

    // ****************************************************
    // clock, timeout, helpers
    // ****************************************************
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total = err_total + 1;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    // no wait count assumed; timeout ends a hang
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic rd(input logic [7:0] idx, input logic [31:0] mk, input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        chk(r & mk, e);
    endtask : rd

    task automatic pulse(input logic [15:0] v);
        load_ua <= v;
        tick(6);
        load_ua <= 16'h0;
        tick(6);
    endtask : pulse

    task automatic toggles(input int n);
        logic p;
        p = gpio_out[4];
        t = 0;
        repeat (n) begin
            @(posedge hclk);
            t += (gpio_out[4] != p);
            p = gpio_out[4];
        end
    endtask : toggles

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        load_ua = 16'h0;
        {fll_lock_raw, temp_ok_raw, ext} = 8'(rnd());
        tick(10);
        hresetn <= 1'b1;
        tick(1);
        rd(ST, 32'h63f, {26'h0, ext});
        rd(EN, 32'h600, 32'h0);
        rd(PO, 32'h600, 32'h0);
        rd(BI, 32'hfc, 32'h0);
        rd(8'h20, 32'hffffffff, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            m = (i % 3 == 2) ? 32'hfc : 32'h600;
            d = (i == 8) ? m : rnd() & m;
            bus(1'b1, rw_idx[i % 3], d);
            rd(rw_idx[i % 3], m, d);
        end
        chk({26'h0, bias_cfg}, 32'h3f);
        $display("test regs done");
        bus(1'b1, PO, 32'h0);
        bus(1'b1, BI, 32'h04);
        bus(1'b1, EN, 32'h600);
        bus(1'b1, ST, 32'h600);
        pulse(16'd300);
        rd(ST, 32'h600, 32'h200);
        pulse(16'd500);
        rd(ST, 32'h600, 32'h600);
        chk({31'h0, codec_irq}, 32'h1);
        bus(1'b1, ST, 32'h200);
        rd(ST, 32'h600, 32'h400);
        bus(1'b1, EN, 32'h200);
        tick(2);
        chk({31'h0, codec_irq}, 32'h0);
        rd(ST, 32'h600, 32'h400);
        bus(1'b1, ST, 32'h400);
        rd(ST, 32'h600, 32'h0);
        $display("test flags done");
        bus(1'b1, PO, 32'h200);
        tick(6);
        rd(ST, 32'h600, 32'h200);
        chk({31'h0, codec_irq}, 32'h1);
        bus(1'b1, ST, 32'h200);
        rd(ST, 32'h600, 32'h200);
        $display("test polarity done");
        bus(1'b1, PO, 32'h600);
        bus(1'b1, mad_pkg::IDX_ROUTE, 32'h01);
        bus(1'b1, mad_pkg::IDX_PULL, 32'h0201);
        chk({20'h0, pin_pulldown_en, pin_pullup_en}, 32'h81);
        bus(1'b1, mad_pkg::IDX_PULL, 32'h0);
        bus(1'b1, mad_pkg::IDX_PIN_SEL, 32'h543298);
        load_ua <= 16'd500;
        tick(6);
        chk({26'h0, gpio_out}, {26'h0, temp_ok_raw, fll_lock_raw, 4'hb});
        chk({26'h0, gpio_oe_n}, 32'h0);
        bus(1'b1, mad_pkg::IDX_PIN_SEL, 32'h610ba7);
        tick(3);
        chk({26'h0, gpio_out & 6'h17}, 32'h7);
        chk({26'h0, gpio_oe_n}, 32'h28);
        load_ua <= 16'h0;
        tick(6);
        chk({26'h0, gpio_out & 6'h06}, 32'h0);
        $display("test pins done");
        for (int i = 0; i < 2; i++) begin
            d = rnd() & 32'h0f;
            bus(1'b1, mad_pkg::IDX_CLK_CTRL, {d[30:0], 1'b1});
            tick(40);
            toggles(8 * (d + 1));
            chk(t, 8);
        end
        bus(1'b1, mad_pkg::IDX_CLK_CTRL, 32'h0);
        tick(3);
        toggles(40);
        chk(t + gpio_out[4], 0);
        $display("test clock done");
        bus(1'b1, EN, 32'h0);
        bus(1'b1, mad_pkg::IDX_ROUTE, 32'h03);
        tick(2);
        chk({30'h0, alt_master_clock_sel, gpio_oe_n[1]}, 32'h3);
        $display("test mclk done");
        end_sim();
    end
endmodule : mad_top_bench

bind mad_top mad_top_sva mad_top_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .det_raw, .bias_cfg, .codec_irq, .main_irq_det,
    .gpio_oe_n, .alt_master_clock_sel);
